/* src/pdc_top.sv */
// pace detection configuration register with apb slave
//
// Summary of operation
// - The configuration register sits at address 0x04 and resets to filters on, detectors C/B/A on aVF/I/II, all off.
// - Bit 11 enables the width filter, bit 10 validation filter B, bit 9 validation filter A, each read/write.
// - A filter bit of one applies that filter, zero bypasses it, and each resets to one.
// - Bits [8:7], [6:5], [4:3] pick the lead of detectors C, B, A: 00 I, 01 II, 10 III, 11 aVF.
// - Bits 2, 1, 0 run detectors C, B, A on their selected lead when one and idle them when zero.
// - Every detector run bit resets to zero so nothing runs until software enables it.
// - A reduced variant stores none of the pace controls and the register then reads as zero.
`timescale 1ns/1ps
`include "pdc_consts.svh"
module pdc_top #(
    parameter bit FULL_FEATURE = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`PDC_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pulse_width_filter_en,
    output logic validation_filter_b_en,
    output logic validation_filter_a_en,
    output logic [2:0] detector_run,
    output logic [11:0] detector_lead
);
    import pdc_pkg::*;

    localparam pdc_cfg_t CFG_RST = FULL_FEATURE ? `PDC_CONFIG_RESET : 24'h000000;
    localparam pdc_cfg_t CFG_MASK = FULL_FEATURE ? `PDC_FIELD_MASK : 24'h000000;
    // index 0 is detector a, so the pattern lists a first
    localparam pdc_lead_t LEAD_RST [3] = '{pdc_lead_t'(`PDC_LEAD_SEL_A_RST),
        pdc_lead_t'(`PDC_LEAD_SEL_B_RST), pdc_lead_t'(`PDC_LEAD_SEL_C_RST)};

    function automatic logic addr_hit(input logic [`PDC_ADDR_W-1:0] a);
        addr_hit = (a == `PDC_ADDR_CONFIG);
    endfunction

    pdc_cfg_t cfg_reg;
    pdc_cfg_t cfg_next;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    wire logic setup = psel & ~penable;
    wire logic access = psel & penable & pready_reg;
    wire logic hit = addr_hit(paddr);
    wire logic wr_en = access & pwrite & hit;
    wire pdc_cfg_t wmask = {{8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    // reserved bits never store, and reduced variant stores nothing
    wire pdc_cfg_t cfg_wr = ((cfg_reg & ~wmask) | (pwdata[23:0] & wmask)) & CFG_MASK;
    wire logic [31:0] prdata_next = (setup & hit) ? {`PDC_RDATA_PAD, cfg_reg} : `PDC_RDATA_ZERO;
    assign cfg_next = wr_en ? cfg_wr : cfg_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= CFG_RST;
            prdata_reg <= `PDC_RDATA_ZERO;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            prdata_reg <= prdata_next;
            pready_reg <= setup;
            pslverr_reg <= setup & ~hit;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pulse_width_filter_en = cfg_reg[`PDC_BIT_WIDTH_FILT];
    assign validation_filter_b_en = cfg_reg[`PDC_BIT_VALID_B];
    assign validation_filter_a_en = cfg_reg[`PDC_BIT_VALID_A];

    // index 0 is detector a, 1 is b, 2 is c
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_det
            pdc_lead_map #(
                .RESET_LEAD(LEAD_RST[g])
            ) u_map (
                .pclk(pclk),
                .presetn(presetn),
                .lead_sel(pdc_lead_t'(cfg_reg[`PDC_SEL_A_LSB + g*`PDC_SEL_W +: `PDC_SEL_W])),
                .run_en(cfg_reg[`PDC_EN_LSB + g]),
                .lead_onehot_reg(detector_lead[g*4 +: 4]),
                .run_reg(detector_run[g])
            );
        end
    endgenerate

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PREADY_AFTER_SETUP: assert property (setup |=> pready ##1 !pready or !psel)
        else $error("pready not one cycle after setup");
    AST_READ_DATA: assert property (setup && hit |=> prdata == {`PDC_RDATA_PAD, $past(cfg_reg)})
        else $error("read data differs from register");
    AST_UNMAPPED_ERR: assert property (setup && !hit |=> pslverr && prdata == `PDC_RDATA_ZERO)
        else $error("unmapped access not flagged");
    AST_RESERVED_ZERO: assert property (cfg_reg[`PDC_RESERVED_MSB:`PDC_RESERVED_LSB] == `PDC_RSV_ZERO)
        else $error("reserved bits not zero");
    AST_WIDTH_FILT_WRITE: assert property (wr_en && pstrb[1] && FULL_FEATURE
        |=> pulse_width_filter_en == $past(pwdata[`PDC_BIT_WIDTH_FILT]))
        else $error("width filter bit not written");
    AST_VALID_A_WRITE: assert property (wr_en && pstrb[1] && FULL_FEATURE
        |=> validation_filter_a_en == $past(pwdata[`PDC_BIT_VALID_A]))
        else $error("validation filter a bit not written");
    AST_RUN_WRITE: assert property (wr_en && pstrb[0] && FULL_FEATURE
        |=> ##1 detector_run == $past(pwdata[2:0], 2))
        else $error("detector run does not follow write");
    AST_LEAD_MAP: assert property (detector_lead[3:0] == 4'h0 |-> 1'b0)
        else $error("detector a lead one-hot empty");
    AST_LEAD_FOLLOW: assert property (1'b1 |=> detector_lead[11:8]
        == (`PDC_ONEHOT_BASE << $past(cfg_reg[8:7])))
        else $error("detector c lead does not follow select");
    AST_HOLD_NO_WRITE: assert property (!wr_en |=> $stable(cfg_reg))
        else $error("register changed without write");
    AST_RUN_NEEDS_EN: assert property (1'b1 |=> detector_run == $past(cfg_reg[2:0]))
        else $error("detector run differs from its enable bits");
    AST_REDUCED_ZERO: assert property (!FULL_FEATURE |-> cfg_reg == 24'h000000)
        else $error("reduced variant holds pace settings");

    COV_WRITE: cover property (wr_en);
    COV_READ: cover property (setup && hit && !pwrite ##1 pready);
    COV_UNMAPPED: cover property (setup && !hit ##1 pslverr);
    COV_ALL_RUN: cover property (detector_run == 3'h7);
endmodule

/* src/pdc_consts.svh */
// constants for the pace detection configuration register
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH
`define PDC_ADDR_W 12
`define PDC_ADDR_CONFIG 12'h004
`define PDC_CONFIG_RESET 24'h000F88
`define PDC_FIELD_MASK 24'h000FFF
`define PDC_BIT_WIDTH_FILT 11
`define PDC_BIT_VALID_B 10
`define PDC_BIT_VALID_A 9
`define PDC_SEL_A_LSB 3
`define PDC_SEL_W 2
`define PDC_EN_LSB 0
`define PDC_RESERVED_MSB 23
`define PDC_RESERVED_LSB 12
`define PDC_RSV_ZERO 12'h000
`define PDC_RDATA_PAD 8'h00
`define PDC_RDATA_ZERO 32'h0000_0000
`define PDC_ONEHOT_BASE 4'h1
`define PDC_LEAD_SEL_A_RST 2'h1
`define PDC_LEAD_SEL_B_RST 2'h0
`define PDC_LEAD_SEL_C_RST 2'h3
`endif

/* src/pdc_pkg.sv */
// types shared by the pace detection configuration block
package pdc_pkg;
    typedef enum logic [1:0] {
        PDC_LEAD_I,
        PDC_LEAD_II,
        PDC_LEAD_III,
        PDC_LEAD_AVF
    } pdc_lead_t;
    typedef logic [23:0] pdc_cfg_t;
endpackage

/* src/pdc_lead_map.sv */
// one pace detector's registered lead one-hot and run enable
`timescale 1ns/1ps
`include "pdc_consts.svh"
module pdc_lead_map #(
    parameter pdc_pkg::pdc_lead_t RESET_LEAD = pdc_pkg::PDC_LEAD_I
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire pdc_pkg::pdc_lead_t lead_sel,
    input wire logic run_en,
    output logic [3:0] lead_onehot_reg,
    output logic run_reg
);
    import pdc_pkg::*;

    localparam logic [3:0] ONEHOT_RST = `PDC_ONEHOT_BASE << RESET_LEAD;
    wire logic [3:0] lead_onehot_next = `PDC_ONEHOT_BASE << lead_sel;

    // new settings apply to the samples after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lead_onehot_reg <= ONEHOT_RST;
            run_reg <= 1'b0;
        end else begin
            lead_onehot_reg <= lead_onehot_next;
            run_reg <= run_en;
        end
    end
endmodule

/* tb/pdc_top_tb.sv */
// self-checking bench for the pace detection configuration register
`timescale 1ns/1ps
`include "pdc_consts.svh"
module pdc_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr, fw, fb, fa, er;
    logic [2:0] detector_run;
    logic [11:0] detector_lead;
    logic [31:0] w;
    logic [31:0] prdata_red, rd_red;
    logic pready_red, pslverr_red, rfw, rfb, rfa;
    logic [2:0] run_red;
    logic [11:0] lead_red;
    int errors = 0, samples_checked = 0, cycles = 0;
    pdc_top pdc_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pulse_width_filter_en(fw), .validation_filter_b_en(fb), .validation_filter_a_en(fa),
        .detector_run(detector_run), .detector_lead(detector_lead));
    // reduced variant on the same bus, answering in step with the full one
    pdc_top #(.FULL_FEATURE(1'b0)) pdc_top_reduced_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_red),
        .pready(pready_red), .pslverr(pslverr_red), .pulse_width_filter_en(rfw), .validation_filter_b_en(rfb),
        .validation_filter_a_en(rfa), .detector_run(run_red), .detector_lead(lead_red));
    initial begin
        forever #4 pclk = ~pclk;
    end
    task automatic report_and_stop;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles >= 5000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rd_red = prdata_red;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [3:0] oh(input logic [1:0] c);
        return 4'h1 << c;
    endfunction
    // check readback and the settled outputs against a 12-bit field image
    task automatic chk_all(input logic [11:0] v);
        apb(`PDC_ADDR_CONFIG, 1'b0, 32'h0000_0000, 4'hF);
        chk("readback", {20'h00000, v}, rd);
        chk("read err", 32'h0000_0000, {31'h0, er});
        chk("reduced readback", 32'h0000_0000, rd_red);
        repeat (3) @(posedge pclk);
        chk("filters", {29'h0, v[11:9]}, {29'h0, fw, fb, fa});
        chk("run", {29'h0, v[2:0]}, {29'h0, detector_run});
        chk("leads", {20'h0, oh(v[8:7]), oh(v[6:5]), oh(v[4:3])}, {20'h0, detector_lead});
        chk("reduced controls", 32'h0000_0000, {26'h0, rfw, rfb, rfa, run_red});
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk_all(12'hF88);
        for (int k = 0; k < 4; k++) begin
            w = {20'hFFFFF, 3'(k * 3), 2'(k + 2), 2'(k + 1), 2'(k), 3'(k * 5)};
            apb(`PDC_ADDR_CONFIG, 1'b1, w, 4'hF);
            chk_all(w[11:0]);
        end
        apb(`PDC_ADDR_CONFIG, 1'b1, 32'h0000_0000, 4'hF);
        apb(`PDC_ADDR_CONFIG, 1'b1, 32'hFFFF_FFFF, 4'h2);
        chk_all(12'hF00);
        apb(12'h008, 1'b1, 32'h0000_0FFF, 4'hF);
        chk("unmapped write err", 32'h1, {31'h0, er});
        apb(12'h008, 1'b0, 32'h0000_0000, 4'hF);
        chk("unmapped read", 32'h1, {rd[30:0], er});
        chk_all(12'hF00);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk_all(12'hF88);
        report_and_stop();
    end
endmodule
